/* File: core/output_compare_regs.svh */
`ifndef OUTPUT_COMPARE_REGS_SVH
`define OUTPUT_COMPARE_REGS_SVH

// ---------------------------------------------------------------------------
// Register map, byte addresses
// ---------------------------------------------------------------------------
`define OC_CHAN_STRIDE      8'h10
`define OC_CTRL_OFS         4'h0
`define OC_PRIMARY_OFS      4'h4
`define OC_SECONDARY_OFS    4'h8
`define OC_TIMER_CTRL_ADDR  8'h50
`define OC_PERIOD_A_ADDR    8'h54
`define OC_PERIOD_B_ADDR    8'h58
`define OC_COUNT_A_ADDR     8'h5c
`define OC_COUNT_B_ADDR     8'h60
`define OC_STATUS_ADDR      8'h64

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define OC_IDLE_STOP_BIT    13
`define OC_FAULT_BIT        4
`define OC_TSEL_BIT         3
`define OC_MODE_LSB         0
`define OC_CTRL_RESET       16'h0000
`define OC_WORD_RESET       16'h0000

// ---------------------------------------------------------------------------
// Bus answers and timing
// ---------------------------------------------------------------------------
`define OC_RESP_OKAY        2'b00
`define OC_RESP_SLVERR      2'b10
`define OC_IRQ_DELAY_CYCLES 2

`endif

/* File: core/output_compare_pkg.sv */
package output_compare_pkg;

  typedef enum logic [2:0] {
    MODE_OFF        = 3'h0,
    MODE_FORCE_HIGH = 3'h1,
    MODE_FORCE_LOW  = 3'h2,
    MODE_TOGGLE     = 3'h3,
    MODE_PULSE_ONE  = 3'h4,
    MODE_PULSE_RUN  = 3'h5,
    MODE_PWM        = 3'h6,
    MODE_PWM_FAULT  = 3'h7
  } oc_mode_t;

  typedef struct packed {
    logic     idle_stop_bit;
    logic     timebase_select;
    oc_mode_t channel_mode_field;
  } oc_ctrl_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic        running;
  } oc_timebase_t;

endpackage

/* File: core/output_compare.sv */
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "output_compare_regs.svh"
// Summary of operation
// R1: Each channel compares its timer against one or two compare values, raising events.
// R2: Timebase select one picks timer B, zero picks timer A.
// R3: Channels run only synchronously with their timebase.
// R4: Idle-stop bit set halts the channel while the processor idles.
// R5: Fault flag sets on fault in PWM-with-fault mode; hardware alone clears it.
// R6: Control bits 15..14 and 12..5 read as zero.
// R7: Mode zero disables the channel.
// R8: Modes 100 and 101 give single and continuous pulses, pin starting low.
// R9: Mode 111 is PWM with fault input, 110 PWM without it.
// R10: Software should disable a channel before picking another mode.
// R11: Single compare modes match primary value against the rising timer.
// R12: Mode 001 starts the pin low until the first match.
// R13: Mode 001 drives the pin high one clock after match, holding it.
// R14: Mode 010 starts the pin high until the first match.
// R15: Mode 010 drives the pin low one clock after match, holding it.
// R16: Flag pulses two clocks after the pin changes on a match; pulse modes flag only the falling edge, and PWM modes never flag.
// R17: Mode 011 toggles the pin on every match, flagging each toggle.
// R18: Each timer counts up to its period then returns to zero.
// R19: Five identical channels, each with control, primary and secondary registers.
// R20: Fault input A serves channels one to four, input B channel five.
// R21: Pin logic clears to zero on reset.
// R22: Primary above period gives no event; pin keeps its initial state. Here PWM modes still drive the pin high at the period match and hold it high.
// R23: Match is sixteen-bit equality of count and primary, checked every clock; here primary and period both zero give no match.
module output_compare #(
  parameter int NUM_CHANNELS = 5,
  parameter int ADDR_WIDTH   = 8
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output      logic                  s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output      logic                  s_axi_wready_o,
  output      logic [1:0]            s_axi_bresp_o,
  output      logic                  s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output      logic                  s_axi_arready_o,
  output      logic [31:0]           s_axi_rdata_o,
  output      logic [1:0]            s_axi_rresp_o,
  output      logic                  s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  input  wire logic                  cpu_idle_i,
  input  wire logic                  fault_input_a_i,
  input  wire logic                  fault_input_b_i,
  output      logic [NUM_CHANNELS-1:0] compare_output_pin_o,
  output      logic [NUM_CHANNELS-1:0] channel_irq_flag_o
);
  import output_compare_pkg::*;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  oc_ctrl_t     ctrl_reg      [NUM_CHANNELS]; // R19
  logic [15:0]  primary_reg   [NUM_CHANNELS];
  logic [15:0]  secondary_reg [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] fault_seen_reg;
  logic [NUM_CHANNELS-1:0] pin_reg;
  oc_timebase_t tb_reg [2];

  logic                  aw_have_reg;
  logic                  w_have_reg;
  logic [ADDR_WIDTH-1:0] waddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  wr_fire;
  logic                  wr_hit;
  logic [31:0]           rd_word;
  logic                  rd_hit;

  // ---------------------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------------------
  // Address and data are taken independently; the write happens once both sit here.
  assign s_axi_awready_o = !aw_have_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_have_reg && !s_axi_bvalid_o;
  assign wr_fire         = aw_have_reg && w_have_reg && !s_axi_bvalid_o;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      aw_have_reg <= 1'b0;
      waddr_reg   <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_reg <= 1'b1;
      waddr_reg   <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      w_have_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata_i;
      wstrb_reg  <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic chan_hit(input logic [ADDR_WIDTH-1:0] a, input int ch, input logic [3:0] ofs);
    chan_hit = (a == ADDR_WIDTH'(ch * `OC_CHAN_STRIDE + ofs));
  endfunction

  always_comb begin
    wr_hit = (waddr_reg == ADDR_WIDTH'(`OC_TIMER_CTRL_ADDR)) || (waddr_reg == ADDR_WIDTH'(`OC_PERIOD_A_ADDR)) ||
             (waddr_reg == ADDR_WIDTH'(`OC_PERIOD_B_ADDR));
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      if (chan_hit(waddr_reg, c, `OC_CTRL_OFS) || chan_hit(waddr_reg, c, `OC_PRIMARY_OFS) ||
          chan_hit(waddr_reg, c, `OC_SECONDARY_OFS)) begin
        wr_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `OC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? `OC_RESP_OKAY : `OC_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr_i)
      ADDR_WIDTH'(`OC_TIMER_CTRL_ADDR): rd_word = {30'h0, tb_reg[1].running, tb_reg[0].running};
      ADDR_WIDTH'(`OC_PERIOD_A_ADDR):   rd_word = {16'h0, tb_reg[0].period};
      ADDR_WIDTH'(`OC_PERIOD_B_ADDR):   rd_word = {16'h0, tb_reg[1].period};
      ADDR_WIDTH'(`OC_COUNT_A_ADDR):    rd_word = {16'h0, tb_reg[0].count};
      ADDR_WIDTH'(`OC_COUNT_B_ADDR):    rd_word = {16'h0, tb_reg[1].count};
      ADDR_WIDTH'(`OC_STATUS_ADDR):     rd_word = 32'(pin_reg);
      default:                          rd_hit  = 1'b0;
    endcase
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      if (chan_hit(s_axi_araddr_i, c, `OC_CTRL_OFS)) begin
        rd_hit  = 1'b1;
        rd_word = '0; // R6
        rd_word[`OC_IDLE_STOP_BIT] = ctrl_reg[c].idle_stop_bit;
        rd_word[`OC_FAULT_BIT]     = fault_seen_reg[c];
        rd_word[`OC_TSEL_BIT]      = ctrl_reg[c].timebase_select;
        rd_word[`OC_MODE_LSB +: 3] = ctrl_reg[c].channel_mode_field;
      end
      if (chan_hit(s_axi_araddr_i, c, `OC_PRIMARY_OFS)) begin
        rd_hit  = 1'b1;
        rd_word = {16'h0, primary_reg[c]};
      end
      if (chan_hit(s_axi_araddr_i, c, `OC_SECONDARY_OFS)) begin
        rd_hit  = 1'b1;
        rd_word = {16'h0, secondary_reg[c]};
      end
    end
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= '0;
      s_axi_rresp_o  <= `OC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_word;
      s_axi_rresp_o  <= rd_hit ? `OC_RESP_OKAY : `OC_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Two selectable up-counting timebases
  // ---------------------------------------------------------------------------
  for (genvar t = 0; t < 2; t++) begin : g_timer
    logic [ADDR_WIDTH-1:0] period_addr;
    assign period_addr = (t == 0) ? ADDR_WIDTH'(`OC_PERIOD_A_ADDR) : ADDR_WIDTH'(`OC_PERIOD_B_ADDR);

    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
        tb_reg[t] <= '{count: `OC_WORD_RESET, period: `OC_WORD_RESET, running: 1'b0};
      end else begin
        if (tb_reg[t].running) begin
          tb_reg[t].count <= (tb_reg[t].count == tb_reg[t].period) ? 16'h0000 : tb_reg[t].count + 16'h0001; // R18
        end
        if (wr_fire && waddr_reg == ADDR_WIDTH'(`OC_TIMER_CTRL_ADDR) && wstrb_reg[0]) begin
          tb_reg[t].running <= wdata_reg[t];
        end
        if (wr_fire && waddr_reg == period_addr) begin
          tb_reg[t].period <= merge16(tb_reg[t].period, wdata_reg, wstrb_reg);
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Compare channels
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
    oc_timebase_t tb;
    oc_mode_t     mode;
    oc_mode_t     mode_prev_reg;
    logic         halted;
    logic         fault_in;
    logic         match_p;
    logic         match_s;
    logic         pulse_done_reg;
    logic         event_reg;
    logic [`OC_IRQ_DELAY_CYCLES-1:0] irq_pipe_reg;

    assign tb       = ctrl_reg[i].timebase_select ? tb_reg[1] : tb_reg[0]; // R2 R3
    assign mode     = ctrl_reg[i].channel_mode_field;
    assign halted   = ctrl_reg[i].idle_stop_bit && cpu_idle_i; // R4
    assign fault_in = (i < 4) ? fault_input_a_i : fault_input_b_i; // R20
    // An empty period with a zero compare value would match forever; treat it as no event.
    assign match_p  = tb.running && (tb.count == primary_reg[i]) &&
                      !(primary_reg[i] == 16'h0000 && tb.period == 16'h0000); // R1 R11 R22 R23
    assign match_s  = tb.running && (tb.count == secondary_reg[i]); // R1

    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
        ctrl_reg[i]      <= oc_ctrl_t'(`OC_CTRL_RESET);
        primary_reg[i]   <= `OC_WORD_RESET;
        secondary_reg[i] <= `OC_WORD_RESET;
      end else if (wr_fire) begin
        if (chan_hit(waddr_reg, i, `OC_CTRL_OFS)) begin
          if (wstrb_reg[1]) begin
            ctrl_reg[i].idle_stop_bit <= wdata_reg[`OC_IDLE_STOP_BIT];
          end
          if (wstrb_reg[0]) begin
            ctrl_reg[i].timebase_select    <= wdata_reg[`OC_TSEL_BIT];
            ctrl_reg[i].channel_mode_field <= oc_mode_t'(wdata_reg[`OC_MODE_LSB +: 3]);
          end
        end
        if (chan_hit(waddr_reg, i, `OC_PRIMARY_OFS)) begin
          primary_reg[i] <= merge16(primary_reg[i], wdata_reg, wstrb_reg);
        end
        if (chan_hit(waddr_reg, i, `OC_SECONDARY_OFS)) begin
          secondary_reg[i] <= merge16(secondary_reg[i], wdata_reg, wstrb_reg);
        end
      end
    end

    // A mode change re-initialises the pin whether or not software passed through off first.
    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
        pin_reg[i]     <= 1'b0; // R21
        mode_prev_reg  <= MODE_OFF;
        pulse_done_reg <= 1'b0;
        event_reg      <= 1'b0;
      end else if (halted) begin
        event_reg <= 1'b0;
      end else begin
        mode_prev_reg <= mode;
        event_reg     <= 1'b0;
        if (mode != mode_prev_reg) begin // R10
          pin_reg[i]     <= (mode == MODE_FORCE_LOW); // R7 R8 R12 R14
          pulse_done_reg <= 1'b0;
        end else begin
          case (mode)
            MODE_FORCE_HIGH: begin
              if (match_p && !pin_reg[i]) begin
                pin_reg[i] <= 1'b1; // R13
                event_reg  <= 1'b1;
              end
            end
            MODE_FORCE_LOW: begin
              if (match_p && pin_reg[i]) begin
                pin_reg[i] <= 1'b0; // R15
                event_reg  <= 1'b1;
              end
            end
            MODE_TOGGLE: begin
              if (match_p) begin
                pin_reg[i] <= !pin_reg[i]; // R17
                event_reg  <= 1'b1;
              end
            end
            MODE_PULSE_ONE, MODE_PULSE_RUN: begin // R8
              if (pin_reg[i] && match_s) begin
                pin_reg[i]     <= 1'b0;
                event_reg      <= 1'b1;
                pulse_done_reg <= (mode == MODE_PULSE_ONE);
              end else if (!pin_reg[i] && match_p && !pulse_done_reg) begin
                pin_reg[i] <= 1'b1;
              end
            end
            MODE_PWM, MODE_PWM_FAULT: begin // R9
              if (mode == MODE_PWM_FAULT && (fault_in || fault_seen_reg[i])) begin
                pin_reg[i] <= 1'b0;
              end else if (tb.running && tb.count == tb.period) begin
                pin_reg[i] <= (primary_reg[i] != 16'h0000);
              end else if (match_p) begin
                pin_reg[i] <= 1'b0;
              end
            end
            default: begin
              pin_reg[i] <= 1'b0; // R7
            end
          endcase
        end
      end
    end

    // The flag is cleared only when the channel leaves fault-protected PWM.
    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
        fault_seen_reg[i] <= 1'b0;
      end else if (mode != MODE_PWM_FAULT) begin
        fault_seen_reg[i] <= 1'b0; // R5
      end else if (fault_in && !halted) begin
        fault_seen_reg[i] <= 1'b1; // R5
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
        irq_pipe_reg <= '0;
      end else begin
        irq_pipe_reg <= {irq_pipe_reg[`OC_IRQ_DELAY_CYCLES-2:0], event_reg}; // R16
      end
    end

    assign channel_irq_flag_o[i] = irq_pipe_reg[`OC_IRQ_DELAY_CYCLES-1];
  end

  assign compare_output_pin_o = pin_reg;

endmodule

/* File: tb/output_compare_asserts.sv */
`timescale 1ns/1ps
module output_compare_asserts #(
  parameter int NUM_CHANNELS = 5
) (
  input wire logic                    sys_clk_i,
  input wire logic                    rstn_i,
  input wire logic                    s_axi_awvalid_i,
  input wire logic                    s_axi_awready_o,
  input wire logic                    s_axi_wvalid_i,
  input wire logic                    s_axi_wready_o,
  input wire logic [1:0]              s_axi_bresp_o,
  input wire logic                    s_axi_bvalid_o,
  input wire logic                    s_axi_bready_i,
  input wire logic                    s_axi_arvalid_i,
  input wire logic                    s_axi_arready_o,
  input wire logic [31:0]             s_axi_rdata_o,
  input wire logic [1:0]              s_axi_rresp_o,
  input wire logic                    s_axi_rvalid_o,
  input wire logic                    s_axi_rready_i,
  input wire logic [NUM_CHANNELS-1:0] compare_output_pin_o,
  input wire logic [NUM_CHANNELS-1:0] channel_irq_flag_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // -------------------------------------------------------------------------
  // Write handshake steps
  // -------------------------------------------------------------------------
  sequence s_write_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_resp_up;
    !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endsequence
  property p_write_answer;
    s_write_taken |=> s_resp_up;
  endproperty
  property p_bvalid_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  property p_rvalid_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o);
  endproperty
  property p_read_answer;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  property p_slots_blocked;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  property p_upper_zero;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000;
  endproperty
  property p_reset_clear;
    $rose(rstn_i) |-> compare_output_pin_o == '0 && channel_irq_flag_o == '0;
  endproperty
  // A new flag must follow an edge of the same pin by exactly two clocks.
  property p_flag_after_edge;
    ((channel_irq_flag_o & ~$past(channel_irq_flag_o)) & ~($past(compare_output_pin_o, 2) ^
      $past(compare_output_pin_o, 3))) == '0;
  endproperty
  property p_flag_pulse;
    (channel_irq_flag_o & $past(channel_irq_flag_o)) == '0;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer changed");
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  a_slots_blocked: assert property (p_slots_blocked) else $error("write taken during answer");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_reset_clear: assert property (p_reset_clear) else $error("pins not clear after reset");
  a_flag_after_edge: assert property (p_flag_after_edge) else $error("flag without pin edge");
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag longer than a clock");
endmodule
bind output_compare output_compare_asserts #(.NUM_CHANNELS(NUM_CHANNELS)) i_output_compare_asserts (
  .sys_clk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .compare_output_pin_o, .channel_irq_flag_o);

/* File: tb/pin_watch.sv */
`timescale 1ns/1ps
// Observes the pins and flags the way a load on the far side would see them.
module pin_watch (
  input  wire logic       clk_i,
  input  wire logic       clear_i,
  input  wire logic [4:0] pin_i,
  input  wire logic [4:0] flag_i,
  output int              edges_o [5],
  output int              flags_o [5],
  output int              first_o [5],
  output int              gap_o   [5]
);
  logic [4:0] prev;
  int         now;
  int         last [5];
  always @(posedge clk_i) begin
    now <= now + 1;
    prev <= pin_i;
    for (int i = 0; i < 5; i++) begin
      if (clear_i) begin
        edges_o[i] <= 0;
        flags_o[i] <= 0;
      end else begin
        if (flag_i[i] === 1'b1) flags_o[i] <= flags_o[i] + 1;
        if (pin_i[i] !== prev[i]) begin
          if (edges_o[i] == 0) first_o[i] <= now;
          else gap_o[i] <= now - last[i];
          last[i] <= now;
          edges_o[i] <= edges_o[i] + 1;
        end
      end
    end
  end
endmodule

/* File: tb/output_compare_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module output_compare_tb_top;
  logic sys_clk_i = 0, rstn_i = 0, clr = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, idle = 0, flt_a = 0, flt_b = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [4:0] pin, flag;
  logic [33:0] exp_q [$];
  logic [33:0] exp_v;
  logic [31:0] seed = 32'hb918;
  int n_fail = 0, tests_run = 0, cyc = 0, edges [5], flags [5], first [5], gap [5];
  always #5 sys_clk_i = ~sys_clk_i;
  output_compare i_output_compare (.sys_clk_i, .rstn_i, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .cpu_idle_i(idle),
    .fault_input_a_i(flt_a), .fault_input_b_i(flt_b), .compare_output_pin_o(pin), .channel_irq_flag_o(flag));
  pin_watch i_pin_watch (.clk_i(sys_clk_i), .clear_i(clr), .pin_i(pin), .flag_i(flag), .edges_o(edges),
    .flags_o(flags), .first_o(first), .gap_o(gap));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // -------------------------------------------------------------------------
  // Bus master: ready is looked at mid-cycle, where it is settled.
  // -------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_go, w_go, b_go;
    exp_q.push_back({r, 32'h0});
    @(posedge sys_clk_i);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge sys_clk_i);
      aw_go = awvalid && awready; w_go = wvalid && wready; b_go = bvalid;
      @(posedge sys_clk_i);
      if (aw_go) awvalid <= 0;
      if (w_go) wvalid <= 0;
    end while (!b_go);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ar_go, r_go;
    exp_q.push_back({r, d});
    @(posedge sys_clk_i);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge sys_clk_i);
      ar_go = arvalid && arready; r_go = rvalid;
      @(posedge sys_clk_i);
      if (ar_go) arvalid <= 0;
    end while (!r_go);
    rready <= 0;
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // Every answer is compared against the oldest expectation.
  always @(negedge sys_clk_i) begin
    if (bvalid === 1'b1 && bready) begin
      exp_v = exp_q.pop_front();
      `CHK({bresp, 32'h0}, exp_v)
    end
    if (rvalid === 1'b1 && rready) begin
      exp_v = exp_q.pop_front();
      `CHK({rresp, rdata}, exp_v)
    end
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    logic [31:0] v;
    run(12);
    rstn_i <= 1;
    for (int c = 0; c < 5; c++) rd(8'(c * 16), 32'h0, 2'b00);
    rd(8'h5c, 32'h0, 2'b00);
    rd(8'h70, 32'h0, 2'b10);
    wr(8'h74, 32'h1, 2'b10);
    // Every mode code once, reserved and status bits randomised.
    for (int m = 0; m < 8; m++) begin
      seed = xs(seed);
      v = {seed[31:3], 3'(m)};
      wr(8'h30, v, 2'b00);
      rd(8'h30, v & 32'h200f, 2'b00);
      wr(8'h30, 32'h0, 2'b00);
    end
    wr(8'h54, 32'd20, 2'b00);
    wr(8'h58, 32'd30, 2'b00);
    wr(8'h04, 32'd5, 2'b00);
    wr(8'h14, 32'd7, 2'b00);
    wr(8'h24, 32'd20, 2'b00);
    wr(8'h34, 32'd25, 2'b00);
    wr(8'h44, 32'd3, 2'b00);
    rd(8'h44, 32'd3, 2'b00);
    wr(8'h00, 32'h0001, 2'b00);
    wr(8'h10, 32'h000a, 2'b00);
    wr(8'h20, 32'h0003, 2'b00);
    wr(8'h30, 32'h0001, 2'b00);
    wr(8'h40, 32'h200b, 2'b00);
    run(4);
    clr <= 0;
    wr(8'h50, 32'h3, 2'b00);
    run(100);
    `CHK(edges[0], 1)
    `CHK(edges[1], 1)
    `CHK(flags[0], 1)
    `CHK(flags[1], 1)
    `CHK(pin[1:0], 2'b01)
    `CHK(first[2] - first[0], 15)
    `CHK(first[1] - first[4], 4)
    `CHK(gap[2], 21)
    `CHK(gap[4], 31)
    `CHK(edges[3] + flags[3], 0)
    `CHK(pin[3], 1'b0)
    clr <= 1;
    idle <= 1;
    run(2);
    clr <= 0;
    run(100);
    `CHK(edges[4], 0)
    `CHK(edges[2] >= 4, 1'b1)
    `CHK(edges[2] - flags[2] <= 1, 1'b1)
    idle <= 0;
    run(40);
    `CHK(edges[4] >= 1, 1'b1)
    wr(8'h20, 32'h0, 2'b00);
    clr <= 1;
    wr(8'h00, 32'h0, 2'b00);
    wr(8'h00, 32'h0004, 2'b00);
    clr <= 0;
    run(50);
    `CHK(edges[2], 0)
    `CHK(edges[0], 2)
    `CHK(flags[0], 1)
    wr(8'h30, 32'h0, 2'b00);
    wr(8'h30, 32'h0007, 2'b00);
    wr(8'h40, 32'h0, 2'b00);
    wr(8'h40, 32'h200f, 2'b00);
    flt_a <= 1;
    run(5);
    `CHK(pin[3], 1'b0)
    rd(8'h30, 32'h0017, 2'b00);
    rd(8'h40, 32'h200f, 2'b00);
    flt_a <= 0;
    flt_b <= 1;
    run(5);
    rd(8'h30, 32'h0017, 2'b00);
    rd(8'h40, 32'h201f, 2'b00);
    wr(8'h30, 32'h0, 2'b00);
    rd(8'h30, 32'h0, 2'b00);
    run(4);
    close_out();
  end
endmodule
